// ===== hw/uotf_pkg.sv
package uotf_pkg;

	// management command codes
	localparam logic [7:0] CMD_VALLEY_UC_THR = 8'h4B;
	localparam logic [7:0] CMD_OT_FAULT_THR = 8'h4F;
	localparam logic [7:0] CMD_OT_REACTION = 8'h50;
	localparam logic [7:0] CMD_OT_WARN_THR = 8'h51;

	// reset values
	localparam logic [15:0] OT_FAULT_THR_RST = 16'hEBE8;
	localparam logic [15:0] OT_WARN_THR_RST = 16'hEB70;
	localparam logic [7:0] OT_REACTION_RST = 8'hBF;

	// reaction field layout
	localparam int MODE_MSB = 7;
	localparam int MODE_LSB = 6;
	localparam int RETRY_MSB = 5;
	localparam int RETRY_LSB = 3;
	localparam int DELAY_MSB = 2;
	localparam int DELAY_LSB = 0;
	localparam logic [1:0] MODE_RETRY = 2'h2;
	localparam logic [1:0] MODE_COOLDOWN = 2'h3;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_ENDLESS = 3'h7;

	// linear-11 layout
	localparam int EXP_MSB = 15;
	localparam int EXP_LSB = 11;
	localparam int MANT_MSB = 10;
	localparam int FIX_W = 48;

	// retry timing
	localparam int CLK_KHZ = 200000;
	localparam int RETRY_UNIT_MS = 35;
	localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * CLK_KHZ;
	localparam int UNIT_CNT_W = 32;
	localparam int UC_CNT_W = 4;

	typedef struct packed {
		logic wr;
		logic rd;
		logic clear_faults;
		logic [7:0] page;
		logic [7:0] code;
		logic [15:0] data;
	} uotf_cmd_t;

	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_LATCH = 4'b0010,
		ST_COOL = 4'b0100,
		ST_WAIT = 4'b1000
	} uotf_ot_state_t;

	typedef struct packed {
		logic [15:0] uc_thr;
		logic [15:0] ot_thr;
		logic [15:0] warn_thr;
		logic [7:0] reaction;
		uotf_ot_state_t ot_state;
		logic [UNIT_CNT_W-1:0] unit_cnt;
		logic [2:0] step_cnt;
		logic [UC_CNT_W-1:0] uc_run;
		logic uc_flag;
		logic ot_flag;
		logic out_en;
	} uotf_chan_t;

	// exponent + 16 is the exponent with its sign bit flipped
	function automatic logic signed [FIX_W-1:0] lin11_to_fix(input logic [15:0] v);
		logic signed [FIX_W-1:0] m;
		logic [4:0] sh;
		m = {{(FIX_W-11){v[MANT_MSB]}}, v[MANT_MSB:0]};
		sh = {~v[EXP_MSB], v[EXP_MSB-1:EXP_LSB]};
		return m <<< sh;
	endfunction

	// most negative mantissa saturates instead of wrapping
	function automatic logic [15:0] lin11_negate(input logic [15:0] v);
		logic [10:0] m;
		m = v[MANT_MSB:0];
		if (m == 11'h400) begin
			return {v[EXP_MSB:EXP_LSB], 11'h3FF};
		end
		return {v[EXP_MSB:EXP_LSB], 11'(~m + 11'h001)};
	endfunction

endpackage

// ===== hw/uotf_lin11_cmp.sv
`timescale 1ns/1ps
module uotf_lin11_cmp
	import uotf_pkg::*;
(
	// operands in linear-11
	input wire logic [15:0] a_i,
	input wire logic [15:0] b_i,
	// results
	output logic a_gt_b_o,
	output logic a_lt_b_o
);

	logic signed [FIX_W-1:0] a_fix;
	logic signed [FIX_W-1:0] b_fix;

	// both sides widened to one fixed point so differing exponents compare fairly
	always_comb begin
		a_fix = lin11_to_fix(a_i);
		b_fix = lin11_to_fix(b_i);
		a_gt_b_o = a_fix > b_fix;
		a_lt_b_o = a_fix < b_fix;
	end

endmodule

// ===== hw/uotf_fault_handler.sv
`timescale 1ns/1ps
// Notes on behaviour
// - undercurrent samples count only once the current-sense blanking interval is over
// - undercurrent fault needs the configured number of consecutive low samples
// - valley and averaged undercurrent share one flag and one response
// - both thresholds are two-byte read/write linear-11 values
// - undercurrent threshold starts as the negated strapped peak overcurrent threshold
// - over-temperature fault when temperature exceeds threshold, default +125 degrees
// - every setting is per channel, chosen by page, and write-protectable
// - over-temperature reaction pulls alert low; flag holds until clear-faults
// - mode 10 disables the output then retries per retry field; retry codes 001 to 110 latch off as 000 does
// - mode 11 holds output off until temperature drops below warning level
// - retry 000 keeps output off until faults are cleared
// - retry 111 retries forever unless commanded off, bias lost or other fault
// - over-temperature restart waits until temperature is below warning level
// - restart spacing is (delay field + 1) times 35 ms
// - reaction setting resets to retry mode, endless retries, longest delay
// - warning threshold is linear-11, default +110 degrees, used for recovery
module uotf_fault_handler
	import uotf_pkg::*;
#(
	parameter int NUM_CH = 2,
	parameter int UNIT_CYCLES = RETRY_UNIT_CYCLES
) (
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RSTN_I,
	// management command port
	input wire uotf_cmd_t CMD_I,
	input wire logic WRITE_PROTECT_I,
	output logic [15:0] RD_DATA_O,
	output logic RD_VALID_O,
	output logic CMD_NACK_O,
	// strap and supervision inputs
	input wire logic [NUM_CH-1:0][15:0] PEAK_OC_STRAP_I,
	input wire logic BIAS_OK_I,
	input wire logic [NUM_CH-1:0] OUTPUT_ON_CMD_I,
	input wire logic [NUM_CH-1:0] OTHER_FAULT_I,
	// current sensing
	input wire logic [NUM_CH-1:0] BLANK_DONE_I,
	input wire logic [NUM_CH-1:0] ISAMPLE_VALID_I,
	input wire logic [NUM_CH-1:0][15:0] ISAMPLE_I,
	input wire logic [NUM_CH-1:0][UC_CNT_W-1:0] UC_CONSEC_I,
	input wire logic [NUM_CH-1:0] AVG_UC_FAULT_I,
	// temperature
	input wire logic [NUM_CH-1:0][15:0] TEMP_I,
	// channel outputs and status
	output logic [NUM_CH-1:0] OUTPUT_EN_O,
	output logic [NUM_CH-1:0] UC_FAULT_O,
	output logic [NUM_CH-1:0] OT_FAULT_O,
	// open-drain alert line
	input wire logic ALERT_LINE_I,
	output logic ALERT_LINE_O,
	output logic ALERT_LINE_OE_N_O
);

	localparam logic [UNIT_CNT_W-1:0] UNIT_LAST = UNIT_CNT_W'(UNIT_CYCLES - 1);

	typedef struct packed {
		uotf_chan_t [NUM_CH-1:0] ch;
		logic init_done;
		logic [15:0] rd_data;
		logic rd_valid;
		logic nack;
		logic alert;
	} uotf_state_t;

	uotf_state_t st;
	uotf_state_t next_st;

	logic [NUM_CH-1:0] temp_hot;
	logic [NUM_CH-1:0] temp_cool;
	logic [NUM_CH-1:0] sample_low;
	logic [NUM_CH-1:0] unused_gt;
	logic [NUM_CH-1:0] unused_ot_lt;
	logic [NUM_CH-1:0] unused_warn_gt;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_cmp
			uotf_lin11_cmp u_ot_cmp (
				.a_i(TEMP_I[g]),
				.b_i(st.ch[g].ot_thr),
				.a_gt_b_o(temp_hot[g]),
				.a_lt_b_o(unused_ot_lt[g])
			);
			uotf_lin11_cmp u_warn_cmp (
				.a_i(TEMP_I[g]),
				.b_i(st.ch[g].warn_thr),
				.a_gt_b_o(unused_warn_gt[g]),
				.a_lt_b_o(temp_cool[g])
			);
			uotf_lin11_cmp u_uc_cmp (
				.a_i(ISAMPLE_I[g]),
				.b_i(st.ch[g].uc_thr),
				.a_gt_b_o(unused_gt[g]),
				.a_lt_b_o(sample_low[g])
			);
		end
	endgenerate

	function automatic logic page_ok(input logic [7:0] page);
		return page < 8'(NUM_CH);
	endfunction

	always_comb begin
		logic [UC_CNT_W-1:0] need;
		logic [UC_CNT_W-1:0] run_inc;
		logic uc_evt;
		logic stop_hard;
		logic [1:0] mode;
		logic [2:0] retry;
		int p;
		need = '0;
		run_inc = '0;
		uc_evt = 1'b0;
		stop_hard = 1'b0;
		mode = '0;
		retry = '0;
		p = 0;
		next_st = st;
		next_st.rd_valid = 1'b0;
		next_st.nack = 1'b0;

		for (int c = 0; c < NUM_CH; c++) begin
			// undercurrent: samples inside the blanking window leave the run count alone
			uc_evt = 1'b0;
			need = (UC_CONSEC_I[c] == '0) ? UC_CNT_W'(1) : UC_CONSEC_I[c];
			if (ISAMPLE_VALID_I[c] && BLANK_DONE_I[c]) begin
				if (sample_low[c]) begin
					run_inc = st.ch[c].uc_run + UC_CNT_W'(1);
					if (run_inc >= need) begin
						uc_evt = 1'b1;
						next_st.ch[c].uc_run = need;
					end else begin
						next_st.ch[c].uc_run = run_inc;
					end
				end else begin
					next_st.ch[c].uc_run = '0;
				end
			end
			// a clear and a new event in one cycle leaves the flag set
			next_st.ch[c].uc_flag = (st.ch[c].uc_flag & ~CMD_I.clear_faults)
				| uc_evt | AVG_UC_FAULT_I[c];
			next_st.ch[c].ot_flag = (st.ch[c].ot_flag & ~CMD_I.clear_faults) | temp_hot[c];

			mode = st.ch[c].reaction[MODE_MSB:MODE_LSB];
			retry = st.ch[c].reaction[RETRY_MSB:RETRY_LSB];
			stop_hard = !BIAS_OK_I || OTHER_FAULT_I[c];

			case (st.ch[c].ot_state)
				ST_RUN: begin
					if (temp_hot[c]) begin
						if (mode == MODE_COOLDOWN) begin
							next_st.ch[c].ot_state = ST_COOL;
						end else if (mode == MODE_RETRY && retry == RETRY_ENDLESS) begin
							next_st.ch[c].ot_state = ST_COOL;
						end else begin
							// unused mode or retry codes fall back to a latched shutdown
							next_st.ch[c].ot_state = ST_LATCH;
						end
					end
				end
				ST_LATCH: begin
					if (CMD_I.clear_faults && !temp_hot[c]) begin
						next_st.ch[c].ot_state = ST_RUN;
					end
				end
				ST_COOL: begin
					if (mode == MODE_RETRY && stop_hard) begin
						next_st.ch[c].ot_state = ST_LATCH;
					end else if (mode == MODE_RETRY && !OUTPUT_ON_CMD_I[c]) begin
						next_st.ch[c].ot_state = ST_RUN;
					end else if (temp_cool[c]) begin
						if (mode == MODE_COOLDOWN) begin
							next_st.ch[c].ot_state = ST_RUN;
						end else begin
							next_st.ch[c].ot_state = ST_WAIT;
							next_st.ch[c].unit_cnt = UNIT_LAST;
							next_st.ch[c].step_cnt = st.ch[c].reaction[DELAY_MSB:DELAY_LSB];
						end
					end
				end
				ST_WAIT: begin
					if (stop_hard) begin
						next_st.ch[c].ot_state = ST_LATCH;
					end else if (!OUTPUT_ON_CMD_I[c]) begin
						next_st.ch[c].ot_state = ST_RUN;
					end else if (temp_hot[c]) begin
						next_st.ch[c].ot_state = ST_COOL;
					end else if (st.ch[c].unit_cnt != '0) begin
						next_st.ch[c].unit_cnt = st.ch[c].unit_cnt - UNIT_CNT_W'(1);
					end else if (st.ch[c].step_cnt != 3'h0) begin
						next_st.ch[c].step_cnt = st.ch[c].step_cnt - 3'h1;
						next_st.ch[c].unit_cnt = UNIT_LAST;
					end else begin
						next_st.ch[c].ot_state = ST_RUN;
					end
				end
				default: begin
					next_st.ch[c].ot_state = ST_LATCH;
				end
			endcase
			next_st.ch[c].out_en = (next_st.ch[c].ot_state == ST_RUN) && OUTPUT_ON_CMD_I[c];
		end

		// strapped defaults are caught on the first edge after reset release
		if (!st.init_done) begin
			next_st.init_done = 1'b1;
			for (int c = 0; c < NUM_CH; c++) begin
				next_st.ch[c].uc_thr = lin11_negate(PEAK_OC_STRAP_I[c]);
			end
		end else if (CMD_I.wr || CMD_I.rd) begin
			p = int'(CMD_I.page);
			if (!page_ok(CMD_I.page)) begin
				next_st.nack = 1'b1;
				// a write beside the read wins, so only a lone read is answered
				next_st.rd_valid = CMD_I.rd && !CMD_I.wr;
				next_st.rd_data = '0;
			end else if (CMD_I.wr) begin
				if (WRITE_PROTECT_I) begin
					next_st.nack = 1'b1;
				end else begin
					case (CMD_I.code)
						CMD_VALLEY_UC_THR: next_st.ch[p].uc_thr = CMD_I.data;
						CMD_OT_FAULT_THR: next_st.ch[p].ot_thr = CMD_I.data;
						CMD_OT_REACTION: next_st.ch[p].reaction = CMD_I.data[7:0];
						CMD_OT_WARN_THR: next_st.ch[p].warn_thr = CMD_I.data;
						default: next_st.nack = 1'b1;
					endcase
				end
			end else begin
				next_st.rd_valid = 1'b1;
				case (CMD_I.code)
					CMD_VALLEY_UC_THR: next_st.rd_data = st.ch[p].uc_thr;
					CMD_OT_FAULT_THR: next_st.rd_data = st.ch[p].ot_thr;
					CMD_OT_REACTION: next_st.rd_data = {8'h00, st.ch[p].reaction};
					CMD_OT_WARN_THR: next_st.rd_data = st.ch[p].warn_thr;
					default: begin
						next_st.rd_data = '0;
						next_st.nack = 1'b1;
					end
				endcase
			end
		end

		next_st.alert = 1'b0;
		for (int c = 0; c < NUM_CH; c++) begin
			if (next_st.ch[c].ot_flag || next_st.ch[c].uc_flag) begin
				next_st.alert = 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			st <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				st.ch[c].ot_thr <= OT_FAULT_THR_RST;
				st.ch[c].warn_thr <= OT_WARN_THR_RST;
				st.ch[c].reaction <= OT_REACTION_RST;
				st.ch[c].ot_state <= ST_RUN;
			end
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		RD_DATA_O = st.rd_data;
		RD_VALID_O = st.rd_valid;
		CMD_NACK_O = st.nack;
		ALERT_LINE_O = 1'b0;
		ALERT_LINE_OE_N_O = ~st.alert;
		for (int c = 0; c < NUM_CH; c++) begin
			OUTPUT_EN_O[c] = st.ch[c].out_en;
			UC_FAULT_O[c] = st.ch[c].uc_flag;
			OT_FAULT_O[c] = st.ch[c].ot_flag;
		end
	end

endmodule

// ===== tb/uotf_fault_handler_asserts.sv
`timescale 1ns/1ps
module uotf_fault_handler_asserts
	import uotf_pkg::*;
#(
	parameter int NUM_CH = 2
) (
	// watched ports
	input wire logic CORE_CLK_I,
	input wire logic RSTN_I,
	input wire uotf_cmd_t CMD_I,
	input wire logic WRITE_PROTECT_I,
	input wire logic RD_VALID_O,
	input wire logic CMD_NACK_O,
	input wire logic [NUM_CH-1:0] BLANK_DONE_I,
	input wire logic [NUM_CH-1:0] ISAMPLE_VALID_I,
	input wire logic [NUM_CH-1:0] AVG_UC_FAULT_I,
	input wire logic [NUM_CH-1:0] OUTPUT_EN_O,
	input wire logic [NUM_CH-1:0] UC_FAULT_O,
	input wire logic [NUM_CH-1:0] OT_FAULT_O,
	input wire logic ALERT_LINE_O,
	input wire logic ALERT_LINE_OE_N_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RSTN_I);
	// channel 0 stands for all; sample and average paths both set the flag one cycle later, the second depth is margin
	wire uc_ev = (ISAMPLE_VALID_I[0] & BLANK_DONE_I[0]) | AVG_UC_FAULT_I[0];
	// the init edge after reset ignores commands
	sequence rd_req;
		$past(RSTN_I) && CMD_I.rd && !CMD_I.wr;
	endsequence
	sequence wr_locked;
		$past(RSTN_I) && CMD_I.wr && WRITE_PROTECT_I;
	endsequence
	read_answer_a: assert property (rd_req |=> RD_VALID_O)
		else $error("read not answered");
	read_cause_a: assert property (RD_VALID_O |-> $past(CMD_I.rd) && !$past(CMD_I.wr))
		else $error("read answer without request");
	write_lock_a: assert property (wr_locked |=> CMD_NACK_O)
		else $error("protected write accepted");
	alert_pull_a: assert property (ALERT_LINE_OE_N_O == !(|{UC_FAULT_O, OT_FAULT_O}))
		else $error("alert does not follow flags");
	alert_level_a: assert property (ALERT_LINE_O == 1'b0)
		else $error("alert driven high");
	ot_sticky_a: assert property ($fell(OT_FAULT_O[0]) |-> $past(CMD_I.clear_faults))
		else $error("temperature flag dropped alone");
	uc_cause_a: assert property ($rose(UC_FAULT_O[0]) |-> $past(uc_ev) || $past(uc_ev, 2))
		else $error("undercurrent flag without event");
	ot_shut_a: assert property ($rose(OT_FAULT_O[0]) |-> !OUTPUT_EN_O[0])
		else $error("output on at temperature fault");
endmodule
bind uotf_fault_handler uotf_fault_handler_asserts #(.NUM_CH(NUM_CH)) uotf_fault_handler_asserts_i (
	.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .CMD_I(CMD_I), .WRITE_PROTECT_I(WRITE_PROTECT_I),
	.RD_VALID_O(RD_VALID_O), .CMD_NACK_O(CMD_NACK_O), .BLANK_DONE_I(BLANK_DONE_I),
	.ISAMPLE_VALID_I(ISAMPLE_VALID_I), .AVG_UC_FAULT_I(AVG_UC_FAULT_I), .OUTPUT_EN_O(OUTPUT_EN_O),
	.UC_FAULT_O(UC_FAULT_O), .OT_FAULT_O(OT_FAULT_O), .ALERT_LINE_O(ALERT_LINE_O),
	.ALERT_LINE_OE_N_O(ALERT_LINE_OE_N_O));

// ===== tb/uotf_host_model.sv
`timescale 1ns/1ps
module uotf_host_model
	import uotf_pkg::*;
(
	// bus side
	input wire logic clk_i,
	output uotf_cmd_t cmd_o,
	input wire logic [15:0] rd_data_i,
	input wire logic rd_valid_i,
	input wire logic nack_i
);
	initial cmd_o = '0;
	task automatic xfer(input logic w, input logic [7:0] pg, cd, input logic [15:0] d,
		output logic [15:0] q, output logic v, n);
		@(negedge clk_i);
		cmd_o = '{w, !w, 1'b0, pg, cd, d};
		@(negedge clk_i);
		q = rd_data_i;
		v = rd_valid_i;
		n = nack_i;
		// released data is scrambled so a stale word cannot pass
		cmd_o = '{1'b0, 1'b0, 1'b0, pg, cd, ~d};
	endtask
	task automatic clr;
		@(negedge clk_i);
		cmd_o.clear_faults = 1'b1;
		@(negedge clk_i);
		cmd_o.clear_faults = 1'b0;
	endtask
endmodule

// ===== tb/uotf_fault_handler_tb.sv
`timescale 1ns/1ps
module uotf_fault_handler_tb;
	import uotf_pkg::*;
	localparam int U = 4;
	logic clk = 1'b0, rstn = 1'b0, wp = 1'b0, rdv, nak, alo, aoe;
	logic [1:0] of = 2'h0, bd = 2'h0, sv = 2'h0, avg = 2'h0, en, uc, ot;
	logic [1:0][15:0] smp = '0, temp = {16'hEB20, 16'hEB20};
	logic [15:0] rdd;
	logic [1:0] onc = 2'h3;
	logic bias = 1'b1;
	uotf_cmd_t cmd;
	int n_mismatch = 0, n_compared = 0;
	wire alert = aoe ? 1'b1 : alo;
	always #2.5 clk = ~clk;
	uotf_host_model uotf_host_model_i (.clk_i(clk), .cmd_o(cmd), .rd_data_i(rdd), .rd_valid_i(rdv), .nack_i(nak));
	uotf_fault_handler #(.NUM_CH(2), .UNIT_CYCLES(U)) uotf_fault_handler_i (
		.CORE_CLK_I(clk), .RSTN_I(rstn), .CMD_I(cmd), .WRITE_PROTECT_I(wp), .RD_DATA_O(rdd),
		.RD_VALID_O(rdv), .CMD_NACK_O(nak), .PEAK_OC_STRAP_I({16'h0400, 16'h0064}), .BIAS_OK_I(bias),
		.OUTPUT_ON_CMD_I(onc), .OTHER_FAULT_I(of), .BLANK_DONE_I(bd), .ISAMPLE_VALID_I(sv),
		.ISAMPLE_I(smp), .UC_CONSEC_I({4'h3, 4'h3}), .AVG_UC_FAULT_I(avg), .TEMP_I(temp),
		.OUTPUT_EN_O(en), .UC_FAULT_O(uc), .OT_FAULT_O(ot), .ALERT_LINE_I(alert),
		.ALERT_LINE_O(alo), .ALERT_LINE_OE_N_O(aoe));
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkb(input string nm, input logic e, g);
		chk(nm, {15'h0, e}, {15'h0, g});
	endtask
	task automatic finish_test;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic acc(input logic w, input logic [7:0] pg, cd, input logic [15:0] d, e, input logic nk);
		logic [15:0] q;
		logic v, n;
		uotf_host_model_i.xfer(w, pg, cd, d, q, v, n);
		chkb("nack", nk, n);
		if (!w) begin
			chkb("rd_valid", 1'b1, v);
			chk("rd_data", e, q);
		end
	endtask
	task automatic wait_en(output int n);
		n = 0;
		while (en[0] !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 400) begin
				chkb("timeout", 1'b1, 1'b0);
				finish_test();
			end
		end
	endtask
	task automatic samp(input logic [15:0] v);
		@(negedge clk);
		sv[0] = 1'b1;
		smp[0] = v;
		@(negedge clk);
		sv[0] = 1'b0;
		smp[0] = ~v;
	endtask
	task automatic t_regs;
		acc(0, 8'h00, 8'h4B, 16'h0, 16'h079C, 1'h0);
		acc(0, 8'h01, 8'h4B, 16'h0, 16'h03FF, 1'h0);
		acc(0, 8'h01, 8'h4F, 16'h0, 16'hEBE8, 1'h0);
		acc(0, 8'h00, 8'h50, 16'h0, 16'h00BF, 1'h0);
		acc(0, 8'h01, 8'h51, 16'h0, 16'hEB70, 1'h0);
		acc(1, 8'h01, 8'h4F, 16'hEBF0, 16'h0, 1'h0);
		acc(0, 8'h01, 8'h4F, 16'h0, 16'hEBF0, 1'h0);
		acc(0, 8'h00, 8'h4F, 16'h0, 16'hEBE8, 1'h0);
		wp = 1'b1;
		acc(1, 8'h00, 8'h50, 16'h00C0, 16'h0, 1'h1);
		wp = 1'b0;
		acc(0, 8'h00, 8'h50, 16'h0, 16'h00BF, 1'h0);
		acc(0, 8'h02, 8'h4F, 16'h0, 16'h0000, 1'h1);
		acc(0, 8'h00, 8'h4C, 16'h0, 16'h0000, 1'h1);
	endtask
	task automatic t_uc;
		repeat (3) samp(16'h0738);
		cyc(2);
		chkb("uc_blank", 1'b0, uc[0]);
		bd[0] = 1'b1;
		repeat (2) samp(16'h0738);
		samp(16'h079C);
		repeat (2) samp(16'h0738);
		cyc(2);
		chkb("uc_run", 1'b0, uc[0]);
		samp(16'h0738);
		cyc(2);
		chkb("uc_set", 1'b1, uc[0]);
		chkb("alert", 1'b0, alert);
		uotf_host_model_i.clr();
		chkb("uc_clr", 1'b0, uc[0]);
		avg[0] = 1'b1;
		cyc(1);
		avg[0] = 1'b0;
		cyc(2);
		chkb("uc_avg", 1'b1, uc[0]);
		uotf_host_model_i.clr();
	endtask
	task automatic t_cool;
		int n;
		acc(1, 8'h00, 8'h50, 16'h00C0, 16'h0, 1'h0);
		temp[0] = 16'hEBE8;
		cyc(3);
		chkb("ot_edge", 1'b0, ot[0]);
		temp[0] = 16'hF208;
		cyc(2);
		chkb("ot_set", 1'b1, ot[0]);
		chkb("alert_ot", 1'b0, alert);
		temp[0] = 16'hEBC0;
		cyc(6);
		chkb("en_warm", 1'b0, en[0]);
		temp[0] = 16'hEB20;
		wait_en(n);
		chkb("cool_on", 1'b1, n <= 2);
		chkb("ot_held", 1'b1, ot[0]);
		uotf_host_model_i.clr();
		chkb("ot_clr", 1'b0, ot[0]);
	endtask
	task automatic t_retry(input logic [2:0] d);
		int n;
		acc(1, 8'h00, 8'h50, {8'h00, 5'h17, d}, 16'h0, 1'h0);
		temp[0] = 16'hF208;
		cyc(2);
		temp[0] = 16'hEBC0;
		cyc(40);
		chkb("retry_warm", 1'b0, en[0]);
		temp[0] = 16'hEB20;
		wait_en(n);
		chkb("gap", 1'b1, n >= (d + 1) * U && n <= (d + 1) * U + 3);
		uotf_host_model_i.clr();
	endtask
	task automatic t_latch;
		logic [9:0] tbl [5] = '{10'h080, 10'h098, 10'h07F, 10'h1B8, 10'h2B8};
		int n;
		foreach (tbl[i]) begin
			acc(1, 8'h00, 8'h50, {8'h00, tbl[i][7:0]}, 16'h0, 1'h0);
			temp[0] = 16'hF208;
			cyc(2);
			temp[0] = 16'hEB20;
			of[0] = tbl[i][8];
			bias = !tbl[i][9];
			cyc(2);
			of[0] = 1'b0;
			bias = 1'b1;
			cyc(40);
			chkb("latched", 1'b0, en[0]);
			uotf_host_model_i.clr();
			wait_en(n);
		end
	endtask
	task automatic t_cmd_off;
		int n;
		acc(1, 8'h00, 8'h50, 16'h00B8, 16'h0, 1'h0);
		temp[0] = 16'hF208;
		cyc(2);
		temp[0] = 16'hEB20;
		onc[0] = 1'b0;
		cyc(3);
		chkb("off_en", 1'b0, en[0]);
		onc[0] = 1'b1;
		wait_en(n);
		chkb("off_resume", 1'b1, n <= 2);
		uotf_host_model_i.clr();
	endtask
	initial begin
		cyc(5);
		rstn = 1'b1;
		cyc(2);
		t_regs();
		t_uc();
		t_cool();
		t_retry(3'h1);
		t_retry(3'h7);
		t_latch();
		t_cmd_off();
		finish_test();
	end
endmodule
